// file: hw/cre_entry.sv
// Reset start, non-maskable interrupt entry and integer register file.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Take a 31-bit reset start address, bits 31 to 1, from the system.
// - Core reset is active low, asserts asynchronously, releases synchronously.
// - After reset release, first fetch comes from the reset start address.
// - Reset clears integer registers x1 through x31 to zero.
// - Take a 31-bit non-maskable interrupt target address, bits 31 to 1.
// - Non-maskable interrupts ignore other interrupts and direct or vectored mode.
// - Interrupt pin is synchronised and requests on a low-to-high transition.
// - Data-bus store or non-blocking load errors raise an internal interrupt.
// - Any non-maskable interrupt redirects the next fetch to the target address.
// - Cause is zero for pin, f0000000 for store, f0000001 for load.
// - First data-bus error address is captured and locked; later ones gated.
// - Unlock write or core reset releases the lock and re-enables signalling.
module cre_entry (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        core_rst_n_i,
    input  wire logic [31:1] rst_vec_i,
    input  wire logic [31:1] nmi_vec_i,
    input  wire logic        nmi_pin_i,
    input  wire logic        dbus_store_err_i,
    input  wire logic        dbus_load_err_i,
    input  wire logic [31:0] dbus_err_addr_i,
    input  wire logic        err_unlock_i,
    input  wire logic        gpr_we_i,
    input  wire logic [4:0]  gpr_waddr_i,
    input  wire logic [31:0] gpr_wdata_i,
    input  wire logic [4:0]  gpr_raddr_i,
    output logic             core_rst_o,
    output logic             fetch_valid_o,
    output logic [31:0]      fetch_addr_o,
    output logic             cause_we_o,
    output logic [31:0]      cause_o,
    output logic [31:0]      err_addr_o,
    output logic             err_locked_o,
    output logic [31:0]      gpr_rdata_o
);
    logic                rst_meta;
    logic                rst_core_n;
    logic                pin_s1;
    logic                pin_s2;
    logic                pin_prev;
    logic                pin_pulse;
    logic                nmi_pend;
    logic                core_in_reset;
    logic                running;
    logic                take_pin;
    logic                store_ok;
    logic                load_ok;
    logic                err_ok;
    logic                err_open;
    logic [31:0]         next_cause;
    cre_pkg::cre_state_t state;
    logic [31:0]         gpr [1:cre_pkg::GPR_NUM-1];

    // Rebuild a full byte address from a halfword-aligned vector bus.
    function automatic logic [31:0] vec_addr(input logic [31:1] v);
        vec_addr = {v, 1'b0};
    endfunction

    // Reset synchroniser: the pin clears both stages at once, release ripples.
    // Two stages keep a release near a clock edge from reaching the core.
    always_ff @(posedge clk_sys_i or negedge core_rst_n_i) begin
        if (!core_rst_n_i) begin
            rst_meta   <= 1'b0;
            rst_core_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_core_n <= rst_meta;
        end
    end

    // The system reset acts on the same logic, but only at a clock edge.
    assign core_in_reset = !rst_core_n || sys_rst_i;

    // Entry sequencer: one start cycle issues the reset fetch, then run.
    always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state <= cre_pkg::CRE_RESET;
        end else if (sys_rst_i) begin
            state <= cre_pkg::CRE_RESET;
        end else begin
            case (state)
                cre_pkg::CRE_RESET: state <= cre_pkg::CRE_START;
                cre_pkg::CRE_START: state <= cre_pkg::CRE_RUN;
                cre_pkg::CRE_RUN:   state <= cre_pkg::CRE_RUN;
                default:            state <= cre_pkg::CRE_RESET;
            endcase
        end
    end

    assign running = (state == cre_pkg::CRE_RUN);

    // Pin path: two stages, then an edge compare into a one-cycle pulse.
    // A pin stuck high gives a single request; it must drop to re-arm.
    always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            pin_prev  <= 1'b0;
            pin_pulse <= 1'b0;
        end else if (sys_rst_i) begin
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            pin_prev  <= 1'b0;
            pin_pulse <= 1'b0;
        end else begin
            pin_s1    <= nmi_pin_i;
            pin_s2    <= pin_s1;
            pin_prev  <= pin_s2;
            pin_pulse <= pin_s2 && !pin_prev;
        end
    end

    // A pin request seen before run is held, so the reset fetch goes first.
    always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
        if (!rst_core_n) begin
            nmi_pend <= 1'b0;
        end else if (sys_rst_i) begin
            nmi_pend <= 1'b0;
        end else begin
            nmi_pend <= (pin_pulse || nmi_pend) && !running;
        end
    end

    // An unlock in the same cycle lets a new error in.
    assign err_open = !err_locked_o || err_unlock_i;
    // Requests count only once the reset fetch has gone out.
    assign take_pin = running && (pin_pulse || nmi_pend);
    assign store_ok = running && dbus_store_err_i && err_open;
    assign load_ok  = running && dbus_load_err_i && err_open;
    assign err_ok   = store_ok || load_ok;

    // Fixed priority picks one cause: pin, then store, then load.
    always_comb begin
        next_cause = cre_pkg::CAUSE_LOAD;
        if (take_pin) begin
            next_cause = cre_pkg::CAUSE_PIN;
        end else if (store_ok) begin
            next_cause = cre_pkg::CAUSE_STORE;
        end
    end

    // Fetch redirect and cause write; no interrupt mode input reaches here.
    // Address and cause hold after the pulse, so a slow reader still sees them.
    always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
        if (!rst_core_n) begin
            fetch_valid_o <= 1'b0;
            fetch_addr_o  <= cre_pkg::WORD_ZERO;
            cause_we_o    <= 1'b0;
            cause_o       <= cre_pkg::WORD_ZERO;
        end else if (sys_rst_i) begin
            fetch_valid_o <= 1'b0;
            fetch_addr_o  <= cre_pkg::WORD_ZERO;
            cause_we_o    <= 1'b0;
            cause_o       <= cre_pkg::WORD_ZERO;
        end else if (state == cre_pkg::CRE_START) begin
            fetch_valid_o <= 1'b1;
            fetch_addr_o  <= vec_addr(rst_vec_i);
            cause_we_o    <= 1'b0;
        end else if (take_pin || err_ok) begin
            fetch_valid_o <= 1'b1;
            fetch_addr_o  <= vec_addr(nmi_vec_i);
            cause_we_o    <= 1'b1;
            cause_o       <= next_cause;
        end else begin
            fetch_valid_o <= 1'b0;
            cause_we_o    <= 1'b0;
        end
    end

    // Error address capture and lock; a new error beats an unlock write.
    always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
        if (!rst_core_n) begin
            err_addr_o   <= cre_pkg::WORD_ZERO;
            err_locked_o <= 1'b0;
        end else if (sys_rst_i) begin
            err_addr_o   <= cre_pkg::WORD_ZERO;
            err_locked_o <= 1'b0;
        end else if (err_ok) begin
            err_addr_o   <= dbus_err_addr_i;
            err_locked_o <= 1'b1;
        end else if (err_unlock_i) begin
            err_locked_o <= 1'b0;
        end
    end

    // Register file; x0 is not stored and always reads as zero.
    // Every entry clears at reset, which rules out a plain memory macro here.
    always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
        if (!rst_core_n) begin
            for (int i = 1; i < cre_pkg::GPR_NUM; i++) begin
                gpr[i] <= cre_pkg::WORD_ZERO;
            end
        end else if (sys_rst_i) begin
            for (int i = 1; i < cre_pkg::GPR_NUM; i++) begin
                gpr[i] <= cre_pkg::WORD_ZERO;
            end
        end else if (gpr_we_i && gpr_waddr_i != cre_pkg::GPR_X0) begin
            gpr[gpr_waddr_i] <= gpr_wdata_i;
        end
    end

    // Registered read port and reset status output.
    always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
        if (!rst_core_n) begin
            gpr_rdata_o <= cre_pkg::WORD_ZERO;
            core_rst_o  <= 1'b1;
        end else begin
            core_rst_o  <= sys_rst_i;
            if (sys_rst_i || gpr_raddr_i == cre_pkg::GPR_X0) begin
                gpr_rdata_o <= cre_pkg::WORD_ZERO;
            end else begin
                gpr_rdata_o <= gpr[gpr_raddr_i];
            end
        end
    end

    // Checks on the entry behaviour.
    // They are off while either reset is active, since outputs are forced.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (core_in_reset);

    a_first_fetch: assert property (
        state == cre_pkg::CRE_START |=> fetch_valid_o && !cause_we_o &&
            fetch_addr_o == vec_addr($past(rst_vec_i)))
        else $error("first fetch not from reset start address");
    a_gpr_cleared: assert property (
        $past(core_in_reset) && !gpr_we_i && gpr_raddr_i != cre_pkg::GPR_X0
        |=> gpr_rdata_o == cre_pkg::WORD_ZERO)
        else $error("register not clear after reset");
    a_pin_edge: assert property (
        $rose(pin_s2) |=> pin_pulse ##1 !pin_pulse)
        else $error("pin edge not turned into one pulse");
    a_pulse_single: assert property (
        pin_pulse |-> $past(pin_s2) && !$past(pin_s2, 2))
        else $error("pulse without a fresh rising edge");
    a_pin_once: assert property (
        pin_pulse |=> !pin_pulse)
        else $error("pin pulse longer than one cycle");
    a_nmi_target: assert property (
        running && (take_pin || err_ok) |=> cause_we_o && fetch_valid_o &&
            fetch_addr_o == vec_addr($past(nmi_vec_i)))
        else $error("interrupt fetch not at target address");
    a_pin_wins: assert property (
        take_pin |=> cause_o == cre_pkg::CAUSE_PIN)
        else $error("pin cause not taken first");
    a_err_cause: assert property (
        !take_pin && store_ok |=> cause_o == cre_pkg::CAUSE_STORE)
        else $error("store error cause wrong");
    a_load_cause: assert property (
        !take_pin && !store_ok && load_ok
        |=> cause_o == cre_pkg::CAUSE_LOAD)
        else $error("load error cause wrong");
    a_lock_gate: assert property (
        err_locked_o && !err_unlock_i && !take_pin &&
            state != cre_pkg::CRE_START |=> !cause_we_o && $stable(err_addr_o))
        else $error("locked error raised an entry");
    a_unlock: assert property (
        err_unlock_i && !err_ok |=> !err_locked_o)
        else $error("unlock did not release capture");
    a_err_capture: assert property (
        err_ok |=> err_locked_o &&
            err_addr_o == $past(dbus_err_addr_i))
        else $error("first error address not captured");
    a_lock_hold: assert property (
        err_locked_o && !err_unlock_i |=> err_locked_o)
        else $error("lock dropped without an unlock");
    a_one_entry: assert property (
        take_pin && err_ok |=> cause_we_o && err_locked_o &&
            cause_o == cre_pkg::CAUSE_PIN)
        else $error("simultaneous requests not merged");
    a_entry_pulse: assert property (
        fetch_valid_o && !take_pin && !err_ok |=> !fetch_valid_o)
        else $error("fetch redirect held longer than one cycle");
    a_x0_zero: assert property (
        gpr_raddr_i == cre_pkg::GPR_X0
        |=> gpr_rdata_o == cre_pkg::WORD_ZERO)
        else $error("register zero did not read as zero");
    a_release_wait: assert property (
        $past(core_in_reset)
        |-> state == cre_pkg::CRE_RESET && !fetch_valid_o)
        else $error("fetch started before reset release settled");

    // Scenarios that the bench should reach at least once.
    c_reset_fetch: cover property (state == cre_pkg::CRE_START ##1
        fetch_valid_o);
    c_pin_entry: cover property (take_pin ##1 cause_we_o);
    c_store_lock: cover property (store_ok ##1 err_locked_o ##[1:8]
        err_unlock_i);
    c_both_same: cover property (take_pin && err_ok);
    c_pend_entry: cover property (nmi_pend && take_pin);
endmodule
`default_nettype wire

// file: hw/cre_pkg.sv
// Constants and types shared by the reset and non-maskable interrupt entry unit.
package cre_pkg;
    localparam int unsigned XLEN      = 32;
    localparam int unsigned VEC_W     = 31;
    localparam int unsigned GPR_NUM   = 32;
    localparam int unsigned GPR_AW    = 5;
    localparam logic [31:0] CAUSE_PIN   = 32'h0000_0000;
    localparam logic [31:0] CAUSE_STORE = 32'hf000_0000;
    localparam logic [31:0] CAUSE_LOAD  = 32'hf000_0001;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
    localparam logic [4:0]  GPR_X0      = 5'h00;

    // Gray-coded entry states: reset, start fetch, run.
    typedef enum logic [1:0] {
        CRE_RESET = 2'b00,
        CRE_START = 2'b01,
        CRE_RUN   = 2'b11
    } cre_state_t;
endpackage

// file: tb/cre_soc_model.sv
// System-side model driving the start and interrupt vectors and the pin.
`timescale 1ns/1ns
`default_nettype none
module cre_soc_model #(
    parameter logic [31:1] RST_VEC = 31'h0002_0000,
    parameter logic [31:1] NMI_VEC = 31'h0002_0080
) (
    input  wire logic        clk_sys_i,
    input  wire logic        fire_i,
    output logic [31:1]      rst_vec_o,
    output logic [31:1]      nmi_vec_o,
    output logic             nmi_pin_o
);
    int unsigned phase = 0;

    // Vectors are hardwired; the start address points into instruction memory.
    assign rst_vec_o = RST_VEC;
    assign nmi_vec_o = NMI_VEC;

    // A request holds the pin high three cycles, then low three, so the
    // synchroniser cannot drop it; with no request the pin rests at zero.
    always @(posedge clk_sys_i) begin
        if (phase != 0) begin
            phase <= phase - 1;
        end else if (fire_i) begin
            phase <= 6;
        end
    end
    assign nmi_pin_o = (phase > 3);
endmodule
`default_nettype wire

// file: tb/cre_entry_tb_top.sv
// Self-checking testbench for the reset and interrupt entry unit.
`timescale 1ns/1ns
`default_nettype none
module cre_entry_tb_top;
    localparam logic [31:0] RA = 32'h0004_0000;
    localparam logic [31:0] NA = 32'h0004_0100;
    logic clk_sys_i = 0, sys_rst_i = 1, core_rst_n_i = 1, fire = 0;
    logic [31:1] rst_vec, nmi_vec;
    logic nmi_pin, st_err = 0, ld_err = 0, unlock = 0, gpr_we = 0;
    logic [31:0] err_addr_in = 32'h0, gpr_wdata = 32'h0;
    logic [4:0] gpr_waddr = 5'h00, gpr_raddr = 5'h00;
    logic core_rst_o, fetch_valid_o, cause_we_o, err_locked_o;
    logic [31:0] fetch_addr_o, cause_o, err_addr_o, gpr_rdata_o;
    int err_count = 0, check_count = 0, cycles = 0;

    cre_soc_model cre_soc_model_i (.clk_sys_i(clk_sys_i), .fire_i(fire),
        .rst_vec_o(rst_vec), .nmi_vec_o(nmi_vec), .nmi_pin_o(nmi_pin));
    cre_entry cre_entry_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .core_rst_n_i(core_rst_n_i), .rst_vec_i(rst_vec), .nmi_vec_i(nmi_vec),
        .nmi_pin_i(nmi_pin), .dbus_store_err_i(st_err),
        .dbus_load_err_i(ld_err), .dbus_err_addr_i(err_addr_in),
        .err_unlock_i(unlock), .gpr_we_i(gpr_we), .gpr_waddr_i(gpr_waddr),
        .gpr_wdata_i(gpr_wdata), .gpr_raddr_i(gpr_raddr),
        .core_rst_o(core_rst_o), .fetch_valid_o(fetch_valid_o),
        .fetch_addr_o(fetch_addr_o), .cause_we_o(cause_we_o),
        .cause_o(cause_o), .err_addr_o(err_addr_o),
        .err_locked_o(err_locked_o), .gpr_rdata_o(gpr_rdata_o));

    // The clock runs at 10 MHz.
    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Counts redirects over n cycles; one-cycle stimuli drop after the first,
    // and only there, so no input is assigned twice in one time step.
    task automatic watch(input int n, input int exp_n, input logic [31:0] a,
                         input logic cc, input logic [31:0] cause);
        int seen;
        seen = 0;
        for (int k = 0; k < n; k++) begin
            @(negedge clk_sys_i);
            if (k == 0) {fire, st_err, ld_err, unlock} = 4'h0;
            if (fetch_valid_o === 1'b1) begin
                seen++;
                chk("fetch_addr", fetch_addr_o, a);
                if (cc) chk("cause_we", {31'h0, cause_we_o}, 32'h1);
                else chk("no_cause_we", {31'h0, cause_we_o}, 32'h0);
                if (cc) chk("cause", cause_o, cause);
            end
        end
        chk("entries", seen, exp_n);
    endtask

    task automatic t_pin;
        @(negedge clk_sys_i);
        fire = 1;
        watch(14, 1, NA, 1, cre_pkg::CAUSE_PIN);
    endtask

    task automatic t_errors;
        @(negedge clk_sys_i);
        st_err = 1;
        err_addr_in = 32'h8000_1234;
        watch(4, 1, NA, 1, cre_pkg::CAUSE_STORE);
        chk("err_addr", err_addr_o, 32'h8000_1234);
        chk("locked", {31'h0, err_locked_o}, 32'h1);
        ld_err = 1;
        err_addr_in = 32'h9000_0040;
        watch(4, 0, NA, 0, 32'h0);
        chk("err_addr_kept", err_addr_o, 32'h8000_1234);
        t_pin();
        unlock = 1;
        watch(3, 0, NA, 0, 32'h0);
        chk("unlocked", {31'h0, err_locked_o}, 32'h0);
        ld_err = 1;
        watch(4, 1, NA, 1, cre_pkg::CAUSE_LOAD);
        chk("err_addr_new", err_addr_o, 32'h9000_0040);
    endtask

    task automatic t_core_reset;
        for (int i = 0; i < 32; i++) begin
            @(negedge clk_sys_i);
            gpr_we = 1;
            gpr_waddr = 5'(i);
            gpr_wdata = 32'ha5a5_0000 | 32'(i);
        end
        @(negedge clk_sys_i);
        gpr_we = 0;
        gpr_raddr = 5'h05;
        @(negedge clk_sys_i);
        chk("gpr_x5", gpr_rdata_o, 32'ha5a5_0005);
        // The load error before still holds the lock, so this one is gated.
        st_err = 1;
        watch(3, 0, NA, 0, 32'h0);
        core_rst_n_i = 0;
        #10 chk("rst_async", {31'h0, core_rst_o}, 32'h1);
        repeat (3) @(negedge clk_sys_i);
        chk("lock_cleared", {31'h0, err_locked_o}, 32'h0);
        core_rst_n_i = 1;
        watch(8, 1, RA, 0, 32'h0);
        for (int i = 0; i < 32; i++) begin
            gpr_raddr = 5'(i);
            @(negedge clk_sys_i);
            chk("gpr_clear", gpr_rdata_o, 32'h0);
        end
    endtask

    // Pin edge and store error meet in one cycle: one entry with the pin
    // cause, while the error address is still captured and locked.
    task automatic t_both;
        @(negedge clk_sys_i);
        fire = 1;
        @(negedge clk_sys_i);
        fire = 0;
        repeat (3) @(negedge clk_sys_i);
        st_err = 1;
        err_addr_in = 32'h8000_0100;
        watch(4, 1, NA, 1, cre_pkg::CAUSE_PIN);
        chk("both_locked", {31'h0, err_locked_o}, 32'h1);
        chk("both_addr", err_addr_o, 32'h8000_0100);
    endtask

    // Hang guard: the sequence needs well under a thousand cycles.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(negedge clk_sys_i);
        sys_rst_i = 0;
        watch(8, 1, RA, 0, 32'h0);
        chk("core_rst", {31'h0, core_rst_o}, 32'h0);
        t_pin();
        t_errors();
        t_core_reset();
        t_pin();
        t_both();
        end_of_test();
    end
endmodule
`default_nettype wire
